// ==== design/dma_hs_regs.svh ====
// Register offsets, field positions and reset values of the DMA handshake block.
// Assumes byte offsets on an 8-bit register port with 32-bit data.
`ifndef DMA_HS_REGS_SVH
`define DMA_HS_REGS_SVH
`define HS_REG_CTRL     8'h00
`define HS_REG_WAIT     8'h04
`define HS_REG_ADDR     8'h08
`define HS_REG_DATA     8'h0c
`define HS_REG_STATUS   8'h10
`define HS_CTRL_EN      0
`define HS_CTRL_MODE_LO 1
`define HS_CTRL_DIR     3
`define HS_CTRL_BANK_LO 4
`define HS_WAIT_WS_LO   0
`define HS_WAIT_HOLD    4
`define HS_WAIT_IDLE    5
`define HS_CTRL_RST     8'h00
`define HS_WAIT_RST     6'h00
`define HS_ADDR_RST     32'h0000_0000
`endif

// ==== design/dma_hs_pkg.sv ====
// Types shared by the DMA handshake block.
// Assumes the constants header is included by the design file.
`default_nettype none
package dma_hs_pkg;
	typedef enum logic [3:0] {S_IDLE = 4'h1, S_STROBE = 4'h2, S_END = 4'h4, S_GAP = 4'h8} hs_state_t;
	typedef enum logic [1:0] {MODE_HS = 2'h0, MODE_EXT = 2'h1, MODE_PACED = 2'h2, MODE_OFF = 2'h3} hs_mode_t;
	typedef struct packed {
		logic [31:0] addr;
		logic        rd_n;
		logic        wr_n;
		logic        sw_n;
		logic        page;
		logic [3:0]  ms_n;
	} membus_t;
endpackage : dma_hs_pkg
`default_nettype wire

// ==== design/dma_hs.sv ====
// DMA request/grant handshake engine with its data FIFO.
// Assumes request, ack and data pins are asynchronous to CLK_I; register port is on CLK_I.
//
// Function
// - A transfer on a channel starts only when that channel's active-low request is seen low.
// - In handshake mode the grant strobe alone latches or enables the external data.
// - In external handshake mode the address, read, write, sync-write, page, bank selects and grant are driven and ack is sampled.
// - In paced master mode the transfer uses address, read, write, bank selects and ack, never the grant.
// - Each request line passes through two clocked stages, so a late edge is recognised two cycles later.
// - On a write a request held low holds off completion until it rises.
// - On a read a request held low prolongs the access by one clock per extra low cycle.
// - The grant low phase is lengthened by one clock per programmed wait state.
// - An address hold or bus idle setting adds one clock between grant rising and the next strobe.
// - On a write the write strobe falls with the grant and rises one clock before it.
// - On a read the read strobe falls with the grant and rises one clock before it.
//
// Implementation choices: the address map and the plain strobed port.
`include "dma_hs_regs.svh"
`default_nettype none

module dma_hs_fifo #(
	parameter int W     = 32,
	parameter int DEPTH = 32
) (
	input  wire logic                     clk_i,
	input  wire logic                     rstn_i,
	input  wire logic                     in_valid_i,
	output logic                          in_ready_o,
	input  wire logic [W-1:0]             in_data_i,
	output logic                          out_valid_o,
	input  wire logic                     out_ready_i,
	output logic [W-1:0]                  out_data_o,
	output logic [$clog2(DEPTH):0]        level_o
);
	localparam int AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wp;
		logic [AW-1:0]           rp;
		logic [AW:0]             cnt;
	} fifo_state_t;
	fifo_state_t r_r, r_nxt;
	logic push, pop;

	always_comb begin
		r_nxt = r_r;
		push  = in_valid_i && (r_r.cnt != (AW+1)'(DEPTH));
		pop   = out_ready_i && (r_r.cnt != '0);
		if (push) begin
			r_nxt.mem[r_r.wp] = in_data_i;
			r_nxt.wp          = r_r.wp + 1'b1;
		end
		if (pop)
			r_nxt.rp = r_r.rp + 1'b1;
		r_nxt.cnt = r_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			r_r.wp  <= '0;
			r_r.rp  <= '0;
			r_r.cnt <= '0;
		end else begin
			r_r.wp  <= r_nxt.wp;
			r_r.rp  <= r_nxt.rp;
			r_r.cnt <= r_nxt.cnt;
		end
		r_r.mem <= r_nxt.mem;
	end

	assign in_ready_o  = r_r.cnt != (AW+1)'(DEPTH);
	assign out_valid_o = r_r.cnt != '0;
	assign out_data_o  = r_r.mem[r_r.rp];
	assign level_o     = r_r.cnt;
endmodule : dma_hs_fifo

////////////////////////////////////////////////////////////////////////////////

module dma_hs
	import dma_hs_pkg::*;
#(
	parameter int NCH        = 2,
	parameter int FIFO_DEPTH = 32,
	parameter int DW         = 32
) (
	input  wire logic            CLK_I,
	input  wire logic            RSTN_I,
	input  wire logic [7:0]      ADDR_I,
	input  wire logic [31:0]     WDATA_I,
	input  wire logic            WR_I,
	input  wire logic            RD_I,
	output logic      [31:0]     RDATA_O,
	input  wire logic [NCH-1:0]  DMA_REQUEST_N_I,
	output logic      [NCH-1:0]  DMA_GRANT_N_O,
	output logic      [31:0]     MEM_ADDR_O,
	output logic                 MEM_RD_N_O,
	output logic                 MEM_WR_N_O,
	output logic                 SYNC_WRITE_SELECT_N_O,
	output logic                 PAGE_O,
	output logic      [3:0]      MEMORY_BANK_SELECT_N_O,
	input  wire logic            ACK_I,
	input  wire logic [DW-1:0]   DATA_I,
	output logic      [DW-1:0]   DATA_O,
	output logic                 DATA_OE_O
);
	localparam int CHW = (NCH > 1) ? $clog2(NCH) : 1;
	localparam int LW  = $clog2(FIFO_DEPTH) + 1;

	typedef struct packed {
		hs_state_t           st;
		logic [NCH-1:0]      req_m;
		logic [NCH-1:0]      req_s;
		logic                ack_m;
		logic                ack_s;
		logic [DW-1:0]       din_m;
		logic [DW-1:0]       din_s;
		logic [CHW-1:0]      ch;
		hs_mode_t            mode;
		logic                dir;
		logic [3:0]          wcnt;
		logic [23:0]         last_page;
		logic [31:0]         base;
		logic [7:0]          ctrl;
		logic [5:0]          waitcfg;
		logic [NCH-1:0]      grant_n;
		membus_t             bus;
		logic [DW-1:0]       dout;
		logic                oe;
		logic                push;
		logic [DW-1:0]       pdata;
		logic [31:0]         rdata;
	} top_state_t;

	top_state_t r_r, r_nxt;
	logic            f_in_valid, f_in_ready, f_out_valid, f_out_ready, eng_pop;
	logic [DW-1:0]   f_in_data, f_out_data;
	logic [LW-1:0]   f_level;
	logic            sw_dir, found;
	logic [CHW-1:0]  pick;
	hs_mode_t        cfg_mode;

	assign sw_dir      = r_r.ctrl[`HS_CTRL_DIR];
	assign cfg_mode    = hs_mode_t'(r_r.ctrl[`HS_CTRL_MODE_LO +: 2]);
	assign f_in_valid  = sw_dir ? (WR_I && ADDR_I == `HS_REG_DATA) : r_r.push;
	assign f_in_data   = sw_dir ? WDATA_I[DW-1:0] : r_r.pdata;
	assign f_out_ready = sw_dir ? eng_pop : (RD_I && ADDR_I == `HS_REG_DATA);

	dma_hs_fifo #(.W(DW), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i       (CLK_I),
		.rstn_i      (RSTN_I),
		.in_valid_i  (f_in_valid),
		.in_ready_o  (f_in_ready),
		.in_data_i   (f_in_data),
		.out_valid_o (f_out_valid),
		.out_ready_i (f_out_ready),
		.out_data_o  (f_out_data),
		.level_o     (f_level)
	);

	////////////////////////////////////////////////////////////////////////////

	always_comb begin
		r_nxt      = r_r;
		eng_pop    = 1'b0;
		found      = 1'b0;
		pick       = '0;
		r_nxt.push = 1'b0;
		r_nxt.req_m = DMA_REQUEST_N_I;
		r_nxt.req_s = r_r.req_m;
		r_nxt.ack_m = ACK_I;
		r_nxt.ack_s = r_r.ack_m;
		r_nxt.din_m = DATA_I;
		r_nxt.din_s = r_r.din_m;
		// Lowest channel wins
		for (int i = NCH - 1; i >= 0; i--) begin
			if (!r_r.req_s[i]) begin
				found = 1'b1;
				pick  = CHW'(i);
			end
		end
		// Register writes
		if (WR_I) begin
			case (ADDR_I)
				`HS_REG_CTRL: r_nxt.ctrl    = WDATA_I[7:0];
				`HS_REG_WAIT: r_nxt.waitcfg = WDATA_I[5:0];
				`HS_REG_ADDR: r_nxt.base    = WDATA_I;
				default: ;
			endcase
		end
		if (RD_I) begin
			case (ADDR_I)
				`HS_REG_CTRL:   r_nxt.rdata = {24'h0, r_r.ctrl};
				`HS_REG_WAIT:   r_nxt.rdata = {26'h0, r_r.waitcfg};
				`HS_REG_ADDR:   r_nxt.rdata = r_r.base;
				`HS_REG_DATA:   r_nxt.rdata = 32'(f_out_data);
				`HS_REG_STATUS: r_nxt.rdata = {16'h0, 8'(f_level), 4'(r_r.ch), 1'b0,
					!f_in_ready, !f_out_valid, r_r.st != S_IDLE};
				default:        r_nxt.rdata = 32'h0000_0000;
			endcase
		end
		case (r_r.st)
			S_IDLE: begin
				if (r_r.ctrl[`HS_CTRL_EN] && cfg_mode != MODE_OFF && found
					&& (sw_dir ? f_out_valid : f_in_ready)) begin
					r_nxt.st   = S_STROBE;
					r_nxt.ch   = pick;
					r_nxt.mode = cfg_mode;
					r_nxt.dir  = sw_dir;
					r_nxt.wcnt = r_r.waitcfg[`HS_WAIT_WS_LO +: 4];
					if (cfg_mode != MODE_PACED)
						r_nxt.grant_n[pick] = 1'b0;
					if (cfg_mode != MODE_HS) begin
						r_nxt.bus.addr = r_r.base;
						r_nxt.bus.rd_n = sw_dir;
						r_nxt.bus.wr_n = !sw_dir;
						r_nxt.bus.sw_n = !(sw_dir && cfg_mode == MODE_EXT);
						r_nxt.bus.page = r_r.base[31:8] == r_r.last_page;
						r_nxt.bus.ms_n = ~(4'h1 << r_r.ctrl[`HS_CTRL_BANK_LO +: 2]);
					end
					if (sw_dir) begin
						eng_pop    = 1'b1;
						r_nxt.dout = f_out_data;
						r_nxt.oe   = 1'b1;
					end
				end
			end
			S_STROBE: begin
				if (r_r.wcnt != 4'h0)
					r_nxt.wcnt = r_r.wcnt - 4'h1;
				else if (r_r.req_s[r_r.ch] && (r_r.mode == MODE_HS || r_r.ack_s)) begin
					r_nxt.st       = S_END;
					r_nxt.bus.rd_n = 1'b1;
					r_nxt.bus.wr_n = 1'b1;
					r_nxt.bus.sw_n = 1'b1;
					if (!r_r.dir) begin
						r_nxt.push  = 1'b1;
						r_nxt.pdata = r_r.din_s;
					end
				end
			end
			S_END: begin
				r_nxt.grant_n   = '1;
				r_nxt.oe        = 1'b0;
				r_nxt.bus.ms_n  = 4'hf;
				r_nxt.bus.page  = 1'b0;
				r_nxt.last_page = r_r.base[31:8];
				r_nxt.base      = r_r.base + 32'h1;
				r_nxt.st        = (r_r.waitcfg[`HS_WAIT_HOLD] || r_r.waitcfg[`HS_WAIT_IDLE])
					? S_GAP : S_IDLE;
			end
			S_GAP:   r_nxt.st = S_IDLE;
			default: r_nxt.st = S_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I) begin
		if (!RSTN_I) begin
			r_r           <= '0;
			r_r.st        <= S_IDLE;
			r_r.mode      <= MODE_HS;
			r_r.req_m     <= '1;
			r_r.req_s     <= '1;
			r_r.grant_n   <= '1;
			r_r.bus       <= '{addr: 32'h0, rd_n: 1'b1, wr_n: 1'b1, sw_n: 1'b1, page: 1'b0, ms_n: 4'hf};
			r_r.ctrl      <= `HS_CTRL_RST;
			r_r.waitcfg   <= `HS_WAIT_RST;
			r_r.base      <= `HS_ADDR_RST;
		end else begin
			r_r <= r_nxt;
		end
	end

	assign RDATA_O                = r_r.rdata;
	assign DMA_GRANT_N_O          = r_r.grant_n;
	assign MEM_ADDR_O             = r_r.bus.addr;
	assign MEM_RD_N_O             = r_r.bus.rd_n;
	assign MEM_WR_N_O             = r_r.bus.wr_n;
	assign SYNC_WRITE_SELECT_N_O  = r_r.bus.sw_n;
	assign PAGE_O                 = r_r.bus.page;
	assign MEMORY_BANK_SELECT_N_O = r_r.bus.ms_n;
	assign DATA_O                 = r_r.dout;
	assign DATA_OE_O              = r_r.oe;

	////////////////////////////////////////////////////////////////////////////

	chk_grant_one_ch: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		$onehot0(~DMA_GRANT_N_O)) else $error("More than one grant low");
	// One check per channel, so the past request is that of the falling grant
	for (genvar c = 0; c < NCH; c++) begin : g_grant_chk
		chk_grant_needs_req: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
			$fell(DMA_GRANT_N_O[c]) |-> !$past(r_r.req_s[c])) else $error("Grant without request");
	end
	chk_paced_no_grant: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		(r_r.mode == MODE_PACED) |-> &DMA_GRANT_N_O) else $error("Grant driven in paced mode");
	chk_hs_no_strobe: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		(r_r.mode == MODE_HS) |-> (MEM_RD_N_O && MEM_WR_N_O)) else $error("Strobe in handshake mode");
	chk_wait_count: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		(r_r.st == S_STROBE && r_r.wcnt != 4'h0) |=> (r_r.st == S_STROBE && r_r.wcnt == $past(r_r.wcnt) - 4'h1))
		else $error("Wait state not counted");
	chk_req_holds: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		(r_r.st == S_STROBE && !r_r.req_s[r_r.ch]) |=> r_r.st == S_STROBE) else $error("Finished under held request");
	chk_gap_cycle: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		(r_r.st == S_END && (r_r.waitcfg[`HS_WAIT_HOLD] || r_r.waitcfg[`HS_WAIT_IDLE]))
		|=> (&DMA_GRANT_N_O && MEM_RD_N_O && MEM_WR_N_O)[*2]) else $error("Missing hold cycle");
	chk_wr_before_grant: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		($rose(MEM_WR_N_O) && r_r.mode == MODE_EXT) |-> (!DMA_GRANT_N_O[r_r.ch] ##1 DMA_GRANT_N_O[r_r.ch]))
		else $error("Write strobe not ahead of grant");
	chk_rd_with_grant: assert property (@(posedge CLK_I) disable iff (!RSTN_I)
		($fell(DMA_GRANT_N_O[r_r.ch]) && r_r.mode == MODE_EXT && !r_r.dir) |-> !MEM_RD_N_O)
		else $error("Read strobe late");
endmodule : dma_hs

`default_nettype wire

// ==== testbench/dma_hs_peer.sv ====
// Peripheral model on the far side of the DMA handshake pins.
// Assumes the bench calls serve() once per transfer; ack is always ready.
`default_nettype none
module dma_hs_peer #(
	parameter int NCH = 2
) (
	input  wire logic           clk_i,
	input  wire logic [NCH-1:0] grant_n_i,
	input  wire logic           rd_n_i,
	input  wire logic           wr_n_i,
	output logic      [NCH-1:0] request_n_o,
	output logic                ack_o,
	output logic      [31:0]    data_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt = 0;
	initial begin
		request_n_o = '1;
		ack_o = 1'b1;
		data_o = 32'h0000_0000;
	end
	// Read data stable while strobed, scrambled otherwise
	always @(posedge clk_i) begin
		if (!(&grant_n_i) || !rd_n_i)
			data_o <= 32'ha5c3_0000 + cnt;
		else
			data_o <= ~data_o;
	end
	// Request opens a transfer, held low hold cycles past the strobe
	task automatic serve(input int ch, input int hold);
		cnt++;
		@(posedge clk_i) request_n_o[ch] <= 1'b0;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (!grant_n_i[ch] || !rd_n_i || !wr_n_i)
				break;
		end
		repeat (hold) @(posedge clk_i);
		request_n_o[ch] <= 1'b1;
	endtask : serve
endmodule : dma_hs_peer
`default_nettype wire

// ==== testbench/dma_hs_tb.sv ====
// Self-checking bench for the DMA handshake engine.
// Assumes register map and link timing as handed over with the design.
`include "dma_hs_regs.svh"
`default_nettype none
module dma_hs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import dma_hs_pkg::*;
	logic CLK_I = 0, RSTN_I = 0, WR_I = 0, RD_I = 0, ACK_I;
	logic [7:0] ADDR_I = '0;
	logic [31:0] WDATA_I = '0, RDATA_O, MEM_ADDR_O, DATA_I, DATA_O, rv;
	logic [1:0] DMA_REQUEST_N_I, DMA_GRANT_N_O;
	logic MEM_RD_N_O, MEM_WR_N_O, SYNC_WRITE_SELECT_N_O, PAGE_O, DATA_OE_O;
	logic [3:0] MEMORY_BANK_SELECT_N_O;
	int failures = 0, checked = 0, gl, sl, gf, sf, w6, sn;
	logic [31:0] ad, dq;
	logic [6:0] pn;
	dma_hs #(.NCH(2)) u_dut (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
		.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .DMA_REQUEST_N_I(DMA_REQUEST_N_I),
		.DMA_GRANT_N_O(DMA_GRANT_N_O), .MEM_ADDR_O(MEM_ADDR_O), .MEM_RD_N_O(MEM_RD_N_O),
		.MEM_WR_N_O(MEM_WR_N_O), .SYNC_WRITE_SELECT_N_O(SYNC_WRITE_SELECT_N_O), .PAGE_O(PAGE_O),
		.MEMORY_BANK_SELECT_N_O(MEMORY_BANK_SELECT_N_O), .ACK_I(ACK_I), .DATA_I(DATA_I),
		.DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O));
	dma_hs_peer #(.NCH(2)) u_peer (.clk_i(CLK_I), .grant_n_i(DMA_GRANT_N_O), .rd_n_i(MEM_RD_N_O),
		.wr_n_i(MEM_WR_N_O), .request_n_o(DMA_REQUEST_N_I), .ack_o(ACK_I), .data_o(DATA_I));
	initial begin
		forever #5 CLK_I = ~CLK_I;
	end
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK_I) begin WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= d; end
		@(posedge CLK_I) WR_I <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge CLK_I) begin RD_I <= 1'b1; ADDR_I <= a; end
		@(posedge CLK_I) RD_I <= 1'b0;
		#1 rv = RDATA_O;
	endtask : rd
	// Runs one transfer, measuring grant and strobe low spans
	task automatic xfer(input int ch, input int hold);
		gl = 0; sl = 0; gf = -1; sf = -1;
		sn = -1;
		fork
			u_peer.serve(ch, hold);
			for (int i = 0; i < 40; i++) begin
				@(posedge CLK_I); #1;
				if (DMA_GRANT_N_O[ch] === 1'b0) begin gl++; if (gf < 0) gf = i; end
				if ((MEM_WR_N_O & MEM_RD_N_O) === 1'b0) begin sl++; if (sf < 0) sf = i; end
				// Bus and data pins at the first strobed cycle
				if (sn < 0 && (DMA_GRANT_N_O[ch] & MEM_WR_N_O & MEM_RD_N_O) === 1'b0) begin
					sn = i;
					ad = MEM_ADDR_O;
					dq = DATA_O;
					pn = {PAGE_O, SYNC_WRITE_SELECT_N_O, MEMORY_BANK_SELECT_N_O, DATA_OE_O};
				end
				if (DMA_GRANT_N_O[1-ch] !== 1'b1) chk(32'(DMA_GRANT_N_O), 32'h3);
			end
		join
	endtask : xfer
	task automatic print_verdict;
		if (failures == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (5000) @(posedge CLK_I);
		failures++;
		print_verdict();
	end
	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge CLK_I);
		RSTN_I <= 1'b1;
		#1 chk({DMA_GRANT_N_O, MEM_WR_N_O, MEMORY_BANK_SELECT_N_O, DATA_OE_O}, 32'hfe);
		wr(`HS_REG_WAIT, 32'h4);
		wr(`HS_REG_CTRL, 32'h9);
		for (int i = 0; i < 5; i++) wr(`HS_REG_DATA, 32'hc0de_0000 + i);
		repeat (10) @(posedge CLK_I);
		#1 chk(32'(DMA_GRANT_N_O), 32'h3);
		xfer(1, 0);
		chk(gl, 6);
		chk(sl, 0);
		chk(gf, 3);
		chk(ad, 32'h0);
		chk(dq, 32'hc0de_0000);
		chk(pn, 32'h3f);
		wr(`HS_REG_CTRL, 32'hb);
		xfer(0, 0);
		chk(sf, gf);
		chk(sl, gl - 1);
		chk(ad, 32'h1);
		chk(dq, 32'hc0de_0001);
		chk(pn, 32'h5d);
		xfer(0, 6);
		w6 = gl;
		xfer(0, 8);
		chk(gl - w6, 2);
		wr(`HS_REG_CTRL, 32'hd);
		xfer(1, 0);
		chk(gl, 0);
		chk(sl, 5);
		chk(ad, 32'h4);
		chk(dq, 32'hc0de_0004);
		chk(pn, 32'h7d);
		wr(`HS_REG_CTRL, 32'h3);
		xfer(1, 6);
		w6 = gl;
		chk(sf, gf);
		chk(sl, gl - 1);
		chk(ad, 32'h5);
		chk(pn, 32'h7c);
		xfer(1, 8);
		chk(gl - w6, 2);
		rd(`HS_REG_DATA);
		chk(rv, 32'ha5c3_0006);
		rd(`HS_REG_DATA);
		chk(rv, 32'ha5c3_0007);
		rd(`HS_REG_STATUS);
		chk(rv[1], 1'b1);
		rd(8'h20);
		chk(rv, 32'h0);
		// Disabled mode ignores a request
		wr(`HS_REG_CTRL, 32'h7);
		xfer(0, 0);
		chk(gl, 0);
		chk(sl, 0);
		// Both channels at once, address hold set
		wr(`HS_REG_WAIT, 32'h10);
		wr(`HS_REG_CTRL, 32'h1);
		gf = -1;
		sf = -1;
		fork
			u_peer.serve(0, 0);
			u_peer.serve(1, 0);
			for (int i = 0; i < 30; i++) begin
				@(posedge CLK_I); #1;
				if (DMA_GRANT_N_O[0] === 1'b0) gf = i;
				if (sf < 0 && DMA_GRANT_N_O[1] === 1'b0) sf = i;
			end
		join
		chk(gf, 7);
		chk(sf - gf, 3);
		print_verdict();
	end
endmodule : dma_hs_tb
`default_nettype wire
